// file: test_vsf_supervisor.sv
// Testbench of the voltage supervisor fault logic
`timescale 1ns/10ps
module test_vsf_supervisor;
	import vsf_pkg::*;
	logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, en = 1'h0, ini = 1'h0;
	logic [7:0] adr = 8'h00, lfsr = 8'h3A;
	logic [31:0] dw = 32'h0, dr;
	logic [5:0] req = 6'h00, cmp, fl;
	logic [2:0] aux = 3'h0;
	logic [4:0] so, o;
	logic ack, rsl;
	vsf_otp_t otp = '{48'h0F0007030A01, 3'h0, 6'h00, 3'h3};
	vsf_thr_t th;
	vsf_reg_off_t off;
	int fail_count = 0, checks = 0, n;
	logic [63:0] exp_q[$];
	vsf_supervisor vsf_supervisor_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dw), .dat_o(dr), .ack_o(ack),
		.failsafe_enable_i(en), .failsafe_init_phase_i(ini), .monitor_cmp_i(cmp), .otp_i(otp),
		.threshold_sel_o(th), .scaling_offset_o(so), .regulator_off_o(off),
		.reset_output_low_o(rsl), .fault_flags_o(fl));
	vsf_rail_model vsf_rail_model_i (.clk_i(clk_i), .req_i(req), .io_assign_i(otp.io_assign),
		.aux_assign_i(aux), .off_i(off), .cmp_o(cmp));
	// **********
	// Tasks
	// **********
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	function automatic logic [7:0] step(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic cmp_v(input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic cmp_rd(input logic [63:0] x);
		cmp_v(x[63:32] & x[31:0], dr & x[31:0]);
	endtask
	// Reads note the expected word and its mask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
		@(posedge clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dw <= d;
		if (!w) exp_q.push_back({d, m});
		do @(posedge clk_i); while (!ack);
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask
	task automatic wflag(input int b);
		n = 0;
		while (fl[b] !== 1'h1 && n < 6000) begin
			@(posedge clk_i);
			n++;
		end
		cmp_v(32'(fl[b]), 32'h1);
	endtask
	task automatic wrap_up();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		if (ack && !we && exp_q.size() > 0) cmp_rd(exp_q.pop_front());
	end
	initial begin
		repeat (60000) @(posedge clk_i);
		fail_count++;
		wrap_up();
	end
	// **********
	// Scenarios
	// **********
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'h0;
		bus(1'h0, 8'h00, 32'h666, 32'hFFF);
		bus(1'h0, 8'h1C, 32'h0, 32'hFFFFFFFF);
		cmp_v(th[31:0], otp.th_sel[31:0]);
		cmp_v(32'(th[47:32]), 32'(otp.th_sel[47:32]));
		otp.th_sel[5] <= 8'hFF;
		repeat (2) @(posedge clk_i);
		cmp_v(32'(th[5]), 32'h0F);
		otp.th_sel[5] <= 8'h0F;
		ini <= 1'h1;
		bus(1'h1, 8'h00, 32'h4E4, 32'h0);
		lfsr = step(lfsr);
		o = 5'(lfsr % 8'h11);
		bus(1'h1, 8'h04, 32'(o), 32'h0);
		bus(1'h1, 8'h08, 32'(~o), 32'h0);
		@(posedge clk_i);
		cmp_v(32'(so), 32'(o));
		bus(1'h1, 8'h04, 32'h3, 32'h0);
		bus(1'h1, 8'h08, 32'h1D, 32'h0);
		bus(1'h0, 8'h14, {11'h0, o, 16'h0500}, 32'h1F0700);
		ini <= 1'h0;
		bus(1'h1, 8'h00, 32'hFFF, 32'h0);
		bus(1'h0, 8'h00, 32'h4E4, 32'hFFF);
		req <= 6'h02;
		repeat (1000) @(posedge clk_i);
		cmp_v(32'(fl), 32'h0);
		en <= 1'h1;
		wflag(1);
		cmp_v(32'(rsl), 32'h1);
		req <= 6'h01;
		wflag(0);
		cmp_v(32'(n >= 2400 && n <= 2700), 32'h1);
		cmp_v(32'({off, rsl}), 32'h11);
		repeat (40) @(posedge clk_i);
		cmp_v(32'({off, fl[0]}), 32'h1);
		req <= 6'h00;
		repeat (8) @(posedge clk_i);
		bus(1'h1, 8'h10, 32'h3F, 32'h0);
		bus(1'h0, 8'h10, 32'h0, 32'h3F);
		for (int a = 0; a < 4; a++) begin
			otp.io_assign <= 3'(a);
			req <= 6'h04;
			wflag(2);
			cmp_v(32'({off, rsl}), 32'({4'h4 >> a, 1'h0}));
			req <= 6'h00;
			repeat (8) @(posedge clk_i);
			bus(1'h1, 8'h10, 32'h3F, 32'h0);
		end
		req <= 6'h08;
		wflag(3);
		cmp_v(32'(rsl), 32'h0);
		req <= 6'h00;
		bus(1'h1, 8'h0C, 32'h2, 32'h0);
		aux <= 3'h2;
		req <= 6'h10;
		wflag(4);
		cmp_v(32'({off, rsl}), 32'h3);
		req <= 6'h00;
		wrap_up();
	end
endmodule

// file: vsf_defs.svh
// Constants for the voltage supervisor fault logic: offsets, fields, reset values, timing
`ifndef VSF_DEFS_SVH
`define VSF_DEFS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define VSF_CLK_PERIOD_NS 10
`define VSF_TICK_NS 1000
`define VSF_TICK_CYCLES (`VSF_TICK_NS / `VSF_CLK_PERIOD_NS)
`define VSF_OV_FILT_SHORT_US 6'h19
`define VSF_OV_FILT_LONG_US 6'h2D
`define VSF_UV_FILT_0_US 6'h05
`define VSF_UV_FILT_1_US 6'h0F
`define VSF_UV_FILT_2_US 6'h19
`define VSF_UV_FILT_3_US 6'h28

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define VSF_ADR_IMPACT 8'h00
`define VSF_ADR_OFFSET 8'h04
`define VSF_ADR_COMPL 8'h08
`define VSF_ADR_AUX_ASSIGN 8'h0C
`define VSF_ADR_FLAGS 8'h10
`define VSF_ADR_STATUS 8'h14

// ****************************************************************
// Fields, encodings and reset values
// ****************************************************************
`define VSF_IMPACT_RST 12'h666
`define VSF_OFFSET_MAX 5'h10
`define VSF_TH_MAX_CODE 8'h0F
`define VSF_ASSIGN_PRE 3'h0
`define VSF_ASSIGN_LIN 3'h1
`define VSF_ASSIGN_THIRD_BUCK_REGULATOR 3'h2
`define VSF_STAT_LIVE_LSB 0
`define VSF_STAT_SVS_BAD 8
`define VSF_STAT_ENABLE 9
`define VSF_STAT_INIT 10
`define VSF_STAT_APPLIED_LSB 16

`endif

// file: vsf_pkg.sv
// Types for the voltage supervisor fault logic
package vsf_pkg;

	// Six monitor channels: 0 core OV, 1 core UV, 2 io OV, 3 io UV, 4 aux OV, 5 aux UV
	typedef logic [5:0][7:0] vsf_thr_t;

	typedef struct packed {
		vsf_thr_t th_sel;
		logic [2:0] ov_filt_sel;
		logic [2:0][1:0] uv_filt_sel;
		logic [2:0] io_assign;
	} vsf_otp_t;

	typedef struct packed {
		logic core_buck;
		logic pre_reg;
		logic linear;
		logic third_buck;
	} vsf_reg_off_t;

	typedef struct packed {
		logic [5:0] sync1;
		logic [5:0] sync2;
		logic [5:0][5:0] cnt;
		logic [5:0] live;
		logic [5:0] flag;
		logic [11:0] impact;
		logic [4:0] offset;
		logic [4:0] compl;
		logic [4:0] applied;
		logic svs_bad;
		logic [2:0] aux_assign;
		logic [6:0] tick;
		vsf_reg_off_t off;
		logic rst_n;
		vsf_thr_t th;
		logic ack;
		logic [31:0] dat;
	} vsf_state_t;

endpackage

// file: vsf_rail_model.sv
// Rail model: comparator results from requested faults
`timescale 1ns/10ps
module vsf_rail_model (
	input wire logic clk_i,
	input wire logic [5:0] req_i,
	input wire logic [2:0] io_assign_i,
	input wire logic [2:0] aux_assign_i,
	input wire vsf_pkg::vsf_reg_off_t off_i,
	output logic [5:0] cmp_o
);
	logic [2:0] dead;
	int cnt [3];
	function automatic logic rail_off(input logic [2:0] a);
		case (a)
			3'h0: return off_i.pre_reg;
			3'h1: return off_i.linear;
			3'h2: return off_i.third_buck;
			default: return 1'h0;
		endcase
	endfunction
	assign dead = {rail_off(aux_assign_i), rail_off(io_assign_i), off_i.core_buck};
	// A switched-off rail takes 20 cycles to discharge, then stays down
	always @(posedge clk_i) begin
		for (int i = 0; i < 3; i++) begin
			if (!req_i[2*i]) cnt[i] <= 0;
			else if (dead[i] || cnt[i] > 0) cnt[i] <= cnt[i] + 1;
		end
	end
	always_comb begin
		cmp_o = req_i;
		for (int i = 0; i < 3; i++) cmp_o[2*i] = req_i[2*i] && cnt[i] < 20;
	end
endmodule

// file: vsf_supervisor.sv
// Voltage supervisor fault logic: deglitch, flags, regulator shutdown, reset impact, scaling
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/10ps
`include "vsf_defs.svh"

module vsf_supervisor #(
	parameter int ADR_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Fail-safe state from the surrounding domain
	input wire logic failsafe_enable_i,
	input wire logic failsafe_init_phase_i,
	// Raw comparator results, one bit per channel
	input wire logic [5:0] monitor_cmp_i,
	input wire vsf_pkg::vsf_otp_t otp_i,
	// Analog and regulator side
	output vsf_pkg::vsf_thr_t threshold_sel_o,
	output logic [4:0] scaling_offset_o,
	output vsf_pkg::vsf_reg_off_t regulator_off_o,
	output logic reset_output_low_o,
	output logic [5:0] fault_flags_o
);
	import vsf_pkg::*;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [5:0] ov_limit(input logic sel);
		logic [5:0] lim;
		lim = sel ? `VSF_OV_FILT_LONG_US : `VSF_OV_FILT_SHORT_US;
		return lim;
	endfunction

	function automatic logic [5:0] uv_limit(input logic [1:0] sel);
		logic [5:0] lim;
		lim = `VSF_UV_FILT_0_US;
		case (sel)
			2'h0: lim = `VSF_UV_FILT_0_US;
			2'h1: lim = `VSF_UV_FILT_1_US;
			2'h2: lim = `VSF_UV_FILT_2_US;
			default: lim = `VSF_UV_FILT_3_US;
		endcase
		return lim;
	endfunction

	// Even channels are overvoltage, odd ones undervoltage
	function automatic logic [5:0] filt_limit(input int ch, input vsf_otp_t otp);
		logic [5:0] lim;
		if ((ch % 2) == 0) begin
			lim = ov_limit(otp.ov_filt_sel[ch/2]);
		end else begin
			lim = uv_limit(otp.uv_filt_sel[ch/2]);
		end
		return lim;
	endfunction

	// Byte-lane merge so a partial write leaves the other lanes alone
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	// Overvoltage code 01 is reserved; it reads as no effect so a stray
	// setting can never pull reset by accident
	function automatic logic ov_asserts(input logic [1:0] code);
		logic r;
		r = 1'b0;
		case (code)
			2'h0: r = 1'b0;
			2'h1: r = 1'b0;
			default: r = 1'b1;
		endcase
		return r;
	endfunction

	function automatic logic uv_asserts(input logic [1:0] code);
		logic r;
		r = 1'b0;
		case (code)
			2'h0: r = 1'b0;
			2'h1: r = 1'b0;
			default: r = 1'b1;
		endcase
		return r;
	endfunction

	// The guard also refuses offsets past the last step, so a corrupt
	// offset can never push the core rail further down
	function automatic logic svs_ok(input logic [4:0] cpl, input logic [4:0] ofs);
		logic r;
		r = 1'b0;
		if (cpl == ~ofs && ofs <= `VSF_OFFSET_MAX) begin
			r = 1'b1;
		end
		return r;
	endfunction

	// Unknown assignment codes mean an external supply, never touched
	function automatic vsf_reg_off_t rail_map(input logic [2:0] sel, input logic ov);
		vsf_reg_off_t r;
		r = '0;
		case (sel)
			`VSF_ASSIGN_PRE: r.pre_reg = ov;
			`VSF_ASSIGN_LIN: r.linear = ov;
			`VSF_ASSIGN_THIRD_BUCK_REGULATOR: r.third_buck = ov;
			default: ;
		endcase
		return r;
	endfunction

	// Read mux; unmapped offsets read as zero
	function automatic logic [31:0] read_word(input logic [7:0] a, input vsf_state_t s,
		input logic en, input logic init);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			`VSF_ADR_IMPACT: r = {20'h00000, s.impact};
			`VSF_ADR_OFFSET: r = {27'h0000000, s.offset};
			`VSF_ADR_COMPL: r = {27'h0000000, s.compl};
			`VSF_ADR_AUX_ASSIGN: r = {29'h00000000, s.aux_assign};
			`VSF_ADR_FLAGS: r = {26'h0000000, s.flag};
			`VSF_ADR_STATUS: begin
				r[`VSF_STAT_LIVE_LSB +: 6] = s.live;
				r[`VSF_STAT_SVS_BAD] = s.svs_bad;
				r[`VSF_STAT_ENABLE] = en;
				r[`VSF_STAT_INIT] = init;
				r[`VSF_STAT_APPLIED_LSB +: 5] = s.applied;
			end
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	localparam logic [6:0] TICK_LAST = 7'(`VSF_TICK_CYCLES - 1);

	vsf_state_t q;
	vsf_state_t d;
	logic tick_now;
	logic hit;
	logic [7:0] adr_w;
	logic [31:0] wdat;
	logic [5:0] clr;
	logic [5:0] set;
	logic rst_req;
	logic imp_rst;
	logic [2:0] io_sel;
	logic [2:0] aux_sel;

	always_comb begin
		d = q;
		tick_now = 1'b0;
		hit = 1'b0;
		adr_w = 8'h00;
		wdat = 32'h0000_0000;
		clr = 6'h00;
		set = 6'h00;
		rst_req = 1'b0;
		imp_rst = 1'b0;
		io_sel = otp_i.io_assign;
		aux_sel = q.aux_assign;

		// ****************************************************************
		// Microsecond tick for the deglitch counters
		// ****************************************************************
		// Counting in 1 us steps keeps counters narrow; error stays below 1 us
		tick_now = (q.tick == TICK_LAST);
		d.tick = tick_now ? 7'h00 : q.tick + 7'h01;

		// ****************************************************************
		// Synchroniser and deglitch
		// ****************************************************************
		d.sync1 = monitor_cmp_i;
		d.sync2 = q.sync1;
		for (int i = 0; i < 6; i++) begin
			if (!failsafe_enable_i) begin
				d.cnt[i] = 6'h00;
				d.live[i] = 1'b0;
			end else if (!q.sync2[i]) begin
				d.cnt[i] = 6'h00;
				d.live[i] = 1'b0;
			end else if (!q.live[i] && tick_now) begin
				if (q.cnt[i] + 6'h01 >= filt_limit(i, otp_i)) begin
					d.live[i] = 1'b1;
				end else begin
					d.cnt[i] = q.cnt[i] + 6'h01;
				end
			end
		end

		// ****************************************************************
		// Reset impact decode
		// ****************************************************************
		// Only bit 1 asserts reset, so reserved 01 acts as no effect
		for (int i = 0; i < 6; i++) begin
			if ((i % 2) == 0) begin
				imp_rst = ov_asserts(q.impact[2*i +: 2]);
			end else begin
				imp_rst = uv_asserts(q.impact[2*i +: 2]);
			end
			if (q.live[i] && imp_rst) begin
				rst_req = 1'b1;
			end
		end
		d.rst_n = ~rst_req;

		// ****************************************************************
		// Regulator shutdown on overvoltage
		// ****************************************************************
		d.off = rail_map(io_sel, q.live[2]) | rail_map(aux_sel, q.live[4]);
		d.off.core_buck = q.live[0];

		// ****************************************************************
		// Threshold codes
		// ****************************************************************
		// Codes above the top step are clamped to the widest window
		for (int i = 0; i < 6; i++) begin
			if (otp_i.th_sel[i] > `VSF_TH_MAX_CODE) begin
				d.th[i] = `VSF_TH_MAX_CODE;
			end else begin
				d.th[i] = otp_i.th_sel[i];
			end
		end

		// ****************************************************************
		// Wishbone slave
		// ****************************************************************
		hit = cyc_i && stb_i && !q.ack;
		adr_w = {adr_i[7:2], 2'b00};
		d.ack = hit;
		if (hit && we_i) begin
			case (adr_w)
				`VSF_ADR_IMPACT: begin
					if (failsafe_init_phase_i) begin
						wdat = merge({20'h00000, q.impact}, dat_i, sel_i);
						d.impact = wdat[11:0];
					end
				end
				`VSF_ADR_OFFSET: begin
					if (failsafe_init_phase_i && sel_i[0]) begin
						d.offset = dat_i[4:0];
					end
				end
				`VSF_ADR_COMPL: begin
					if (failsafe_init_phase_i && sel_i[0]) begin
						d.compl = dat_i[4:0];
						if (svs_ok(dat_i[4:0], q.offset)) begin
							d.applied = q.offset;
							d.svs_bad = 1'b0;
						end else begin
							d.svs_bad = 1'b1;
						end
					end
				end
				`VSF_ADR_AUX_ASSIGN: begin
					if (sel_i[0]) begin
						d.aux_assign = dat_i[2:0];
					end
				end
				`VSF_ADR_FLAGS: begin
					if (sel_i[0]) begin
						clr = dat_i[5:0];
					end
				end
				default: ;
			endcase
		end

		// ****************************************************************
		// Sticky flags: a new fault beats a clear in the same cycle
		// ****************************************************************
		set = failsafe_enable_i ? q.live : 6'h00;
		d.flag = (q.flag & ~clr) | set;

		d.dat = 32'h0000_0000;
		if (hit && !we_i) begin
			d.dat = read_word(adr_w, q, failsafe_enable_i, failsafe_init_phase_i);
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q.sync1 <= 6'h00;
			q.sync2 <= 6'h00;
			q.cnt <= '0;
			q.live <= 6'h00;
			q.flag <= 6'h00;
			q.impact <= `VSF_IMPACT_RST;
			q.offset <= 5'h00;
			q.compl <= 5'h00;
			q.applied <= 5'h00;
			q.svs_bad <= 1'b0;
			q.aux_assign <= 3'h0;
			q.tick <= 7'h00;
			q.off <= '0;
			q.rst_n <= 1'b1;
			q.th <= '0;
			q.ack <= 1'b0;
			q.dat <= 32'h0000_0000;
		end else begin
			q <= d;
		end
	end

	assign dat_o = q.dat;
	assign ack_o = q.ack;
	assign threshold_sel_o = q.th;
	assign scaling_offset_o = q.applied;
	assign regulator_off_o = q.off;
	assign reset_output_low_o = q.rst_n;
	assign fault_flags_o = q.flag;

endmodule

// file: vsf_supervisor_monitor.sv
// Checker of bus timing, flags, regulator shutdown and the scaling guard
`timescale 1ns/10ps
module vsf_supervisor_monitor #(
	parameter int ADR_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADR_W-1:0] adr_i,
	input wire logic ack_o,
	input wire logic failsafe_enable_i,
	input wire logic failsafe_init_phase_i,
	input wire logic [5:0] monitor_cmp_i,
	input wire vsf_pkg::vsf_reg_off_t regulator_off_o,
	input wire logic [4:0] scaling_offset_o,
	input wire logic reset_output_low_o,
	input wire logic [5:0] fault_flags_o
);
	// **********
	// Properties
	// **********
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic req = cyc_i && stb_i;
	wire logic clr_w = req && we_i && adr_i[7:2] == 6'h04;
	// Guard only accepts complement writes during init
	wire logic cpl_w = req && we_i && adr_i[7:2] == 6'h02 && failsafe_init_phase_i;
	ack_next_a: assert property (req && !ack_o |=> ack_o)
		else $error("ack missing");
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack too long");
	core_off_cause_a: assert property ($rose(regulator_off_o.core_buck) |-> $past(monitor_cmp_i[0], 4))
		else $error("core off without overvoltage");
	core_off_release_a: assert property (!monitor_cmp_i[0] [*6] |-> !regulator_off_o.core_buck)
		else $error("core stays off");
	flag_sticky_a: assert property (|($past(fault_flags_o) & ~fault_flags_o) |-> $past(clr_w))
		else $error("flag lost");
	flag_gate_a: assert property (!failsafe_enable_i [*3] |=> (fault_flags_o & ~$past(fault_flags_o)) == 6'h00)
		else $error("flag while disabled");
	reset_cause_a: assert property (!reset_output_low_o |-> $past(|monitor_cmp_i, 4) || $past(|monitor_cmp_i, 5))
		else $error("reset without fault");
	offset_guard_a: assert property ($changed(scaling_offset_o) |-> $past(cpl_w) || $past(cpl_w, 2))
		else $error("offset moved unguarded");
	cover property (regulator_off_o.core_buck);
	cover property (!reset_output_low_o);
	cover property ($changed(scaling_offset_o));
endmodule
bind vsf_supervisor vsf_supervisor_monitor #(.ADR_W(ADR_W)) vsf_supervisor_monitor_i (.*);
